// [charge_current_setting_regs.sv]
// Purpose: Current register and revision field of a one-cell charger control slice.
// Assumes: Requests arrive as one-cycle strobes in the clk domain from the bus engine.
// Notes:   Read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Writing one to bit 7 of the current register pulses charger reset mode; zero does nothing.
// - Bit 7 of the current register always reads back as one.
// - The fast charge code sits in bits 6 to 4 and resets to zero.
// - The fast charge sense target is 37.4 mV plus the code times 6.8 mV.
// - The termination code sits in bits 2 to 0 and resets to binary 001.
// - The termination threshold is 3.4 mV plus the code times 3.4 mV.
// - The current register at 04 resets to 89 hex and bit 3 has no function.
// - The identification register at 03 is read only with a revision code in bits 2 to 0.
module charge_current_setting_regs (
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire charge_current_pkg::reg_req_t      req,
	output var  logic [7:0]                        readData,
	output var  logic                              readValid,
	output var  logic                              chargerResetPulse,
	output var  charge_current_pkg::charge_setting_t setting
);
	import charge_current_pkg::*;

	// ----------------------------------------------------------------
	// Derived constants
	// ----------------------------------------------------------------
	localparam int              FAST_WIDTH        = FAST_MSB - FAST_LSB + 1;
	localparam int              TERM_WIDTH        = TERM_MSB - TERM_LSB + 1;
	localparam int              REV_WIDTH         = REV_MSB - REV_LSB + 1;
	localparam int              SENSE_LIMIT       = int'(10'h3ff);
	localparam int              FAST_TARGET_TOP   = int'(FAST_OFFSET) + int'(FAST_STEP) * 7;
	localparam int              TERM_THRESH_TOP   = int'(TERM_OFFSET) + int'(TERM_STEP) * 7;
	localparam logic [9:0]      FAST_TARGET_RESET = 10'(FAST_OFFSET + FAST_STEP * 10'(FAST_RESET));
	localparam logic [9:0]      TERM_THRESH_RESET = 10'(TERM_OFFSET + TERM_STEP * 10'(TERM_RESET));
	localparam charge_setting_t SETTING_RESET     = '{
		fastChargeCode:     FAST_RESET,
		terminationCode:    TERM_RESET,
		fastSenseTarget:    FAST_TARGET_RESET,
		termSenseThreshold: TERM_THRESH_RESET
	};

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The code fields must match the three-bit codes handed to the charge controller.
	if (FAST_WIDTH != 3 || TERM_WIDTH != 3 || REV_WIDTH != 3) begin : g_bad_field_width
		$error("Code fields of the current register must be three bits wide.");
	end

	// The reset image of the register must agree with the reset value of each field.
	if (CURRENT_RESET[FAST_MSB:FAST_LSB] != FAST_RESET ||
		CURRENT_RESET[TERM_MSB:TERM_LSB] != TERM_RESET) begin : g_bad_reset_image
		$error("Reset image of the current register disagrees with its field resets.");
	end

	// The largest code must still fit the ten-bit sense voltage fields.
	if (FAST_TARGET_TOP > SENSE_LIMIT || TERM_THRESH_TOP > SENSE_LIMIT) begin : g_bad_sense_range
		$error("Sense voltage arithmetic overflows its ten-bit field.");
	end

	// The upper half of the revision codes is kept for later revisions.
	if (REVISION_CODE[2] != 1'b0) begin : g_bad_revision
		$error("Revision code lies in the reserved range.");
	end

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	logic curWrite;
	logic curRead;
	logic identRead;

	// Only the current register decodes writes, so a write to the identification
	// offset reaches no state at all.
	assign curWrite  = req.write && (req.addr == CURRENT_OFFSET);
	assign curRead   = req.read && (req.addr == CURRENT_OFFSET);
	assign identRead = req.read && (req.addr == IDENT_OFFSET);

	// ----------------------------------------------------------------
	// Fast charge code
	// ----------------------------------------------------------------
	logic [2:0] fast_reg;
	logic [2:0] fast_next;

	always_comb begin
		fast_next = fast_reg;
		if (curWrite) begin
			fast_next = req.data[FAST_MSB:FAST_LSB];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_reg <= CURRENT_RESET[FAST_MSB:FAST_LSB];
		end else begin
			fast_reg <= fast_next;
		end
	end

	// ----------------------------------------------------------------
	// Termination code
	// ----------------------------------------------------------------
	logic [2:0] term_reg;
	logic [2:0] term_next;

	always_comb begin
		term_next = term_reg;
		if (curWrite) begin
			term_next = req.data[TERM_MSB:TERM_LSB];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			term_reg <= CURRENT_RESET[TERM_MSB:TERM_LSB];
		end else begin
			term_reg <= term_next;
		end
	end

	// ----------------------------------------------------------------
	// Spare bit
	// ----------------------------------------------------------------
	logic unused_reg;
	logic unused_next;

	// The spare bit drives nothing; it is only kept so that it reads back as written.
	always_comb begin
		unused_next = unused_reg;
		if (curWrite) begin
			unused_next = req.data[UNUSED_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unused_reg <= CURRENT_RESET[UNUSED_BIT];
		end else begin
			unused_reg <= unused_next;
		end
	end

	// ----------------------------------------------------------------
	// Charger reset command
	// ----------------------------------------------------------------
	logic crst_reg;
	logic crst_next;

	// Reset mode is a one-cycle command; a zero in the top bit leaves the charger alone.
	always_comb begin
		crst_next = 1'b0;
		if (curWrite) begin
			crst_next = req.data[RESET_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crst_reg <= 1'b0;
		end else begin
			crst_reg <= crst_next;
		end
	end

	// ----------------------------------------------------------------
	// Threshold arithmetic for the charge controller
	// ----------------------------------------------------------------
	charge_setting_t setting_reg;
	charge_setting_t setting_next;

	// Codes and sense voltages change together, so the controller never sees a mixed pair.
	always_comb begin
		setting_next.fastChargeCode     = fast_next;
		setting_next.terminationCode    = term_next;
		setting_next.fastSenseTarget    = 10'(FAST_OFFSET + FAST_STEP * {7'h00, fast_next});
		setting_next.termSenseThreshold = 10'(TERM_OFFSET + TERM_STEP * {7'h00, term_next});
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			setting_reg <= SETTING_RESET;
		end else begin
			setting_reg <= setting_next;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic       rvalid_reg;
	logic       rvalid_next;

	// Read data holds between reads; a read and a write in one cycle return the old value.
	always_comb begin
		rdata_next  = rdata_reg;
		rvalid_next = req.read;
		if (identRead) begin
			rdata_next                  = 8'h00;
			rdata_next[REV_MSB:REV_LSB] = REVISION_CODE;
		end else if (curRead) begin
			rdata_next[RESET_BIT]         = 1'b1;
			rdata_next[FAST_MSB:FAST_LSB] = fast_reg;
			rdata_next[UNUSED_BIT]        = unused_reg;
			rdata_next[TERM_MSB:TERM_LSB] = term_reg;
		end else if (req.read) begin
			rdata_next = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg  <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign readData          = rdata_reg;
	assign readValid         = rvalid_reg;
	assign chargerResetPulse = crst_reg;
	assign setting           = setting_reg;

endmodule // charge_current_setting_regs
`default_nettype wire

// [charge_current_pkg.sv]
// Purpose: Shared constants and types for the charge current setting registers.
// Assumes: An upstream serial bus engine delivers decoded register writes and reads.
// Notes:   Sense voltages are in units of 0.1 mV so that every step is a whole number.
`default_nettype none
package charge_current_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IDENT_OFFSET    = 8'h03;
	localparam logic [7:0] CURRENT_OFFSET  = 8'h04;

	// ----------------------------------------------------------------
	// Field layout of the current and identification registers
	// ----------------------------------------------------------------
	localparam int         RESET_BIT       = 7;
	localparam int         FAST_MSB        = 6;
	localparam int         FAST_LSB        = 4;
	localparam int         UNUSED_BIT      = 3;
	localparam int         TERM_MSB        = 2;
	localparam int         TERM_LSB        = 0;
	localparam int         REV_MSB         = 2;
	localparam int         REV_LSB         = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CURRENT_RESET   = 8'h89;
	localparam logic [2:0] FAST_RESET      = 3'h0;
	localparam logic [2:0] TERM_RESET      = 3'h1;
	localparam logic [2:0] REVISION_CODE   = 3'h2;  // Arbitrary revision value.

	// ----------------------------------------------------------------
	// Sense voltage arithmetic, 0.1 mV units
	// ----------------------------------------------------------------
	localparam logic [9:0] FAST_OFFSET     = 10'h176; // 37.4 mV.
	localparam logic [9:0] FAST_STEP       = 10'h044; // 6.8 mV.
	localparam logic [9:0] TERM_OFFSET     = 10'h022; // 3.4 mV.
	localparam logic [9:0] TERM_STEP       = 10'h022; // 3.4 mV.

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] data;
	} reg_req_t;

	typedef struct packed {
		logic [2:0] fastChargeCode;
		logic [2:0] terminationCode;
		logic [9:0] fastSenseTarget;
		logic [9:0] termSenseThreshold;
	} charge_setting_t;

endpackage
`default_nettype wire

// [charge_current_assertions.sv]
// Purpose: Port assertions for the charge current register block.
// Assumes: One clk domain, rst_n active low.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module charge_current_assertions (
	input wire logic                              clk,
	input wire logic                              rst_n,
	input wire charge_current_pkg::reg_req_t      req,
	input wire logic [7:0]                        readData,
	input wire logic                              readValid,
	input wire logic                              chargerResetPulse,
	input wire charge_current_pkg::charge_setting_t setting
);
	import charge_current_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire wrCur = req.write && req.addr == CURRENT_OFFSET;
	wire rdId  = req.read && req.addr == IDENT_OFFSET;
	chk_pulse_on_set: assert property (wrCur && req.data[7] |=> chargerResetPulse)
		else $error("reset pulse missing");
	chk_top_bit: assert property (req.read && req.addr == CURRENT_OFFSET |=> readData[7])
		else $error("top bit read as zero");
	chk_fast_store: assert property (wrCur |=> setting.fastChargeCode == $past(req.data[6:4]))
		else $error("fast code not stored");
	chk_term_store: assert property (wrCur |=> setting.terminationCode == $past(req.data[2:0]))
		else $error("termination code not stored");
	chk_fast_target: assert property (setting.fastSenseTarget ==
		FAST_OFFSET + setting.fastChargeCode * FAST_STEP) else $error("fast target wrong");
	chk_term_thresh: assert property (setting.termSenseThreshold ==
		TERM_OFFSET + setting.terminationCode * TERM_STEP) else $error("term threshold wrong");
	chk_ident_read: assert property (rdId |=> readValid && readData == {5'h00, REVISION_CODE})
		else $error("ident read wrong");
	chk_ident_locked: assert property (req.write && req.addr == IDENT_OFFSET |=> $stable(setting))
		else $error("ident write changed setting");
	cover property (wrCur && req.data[7]);
	cover property (rdId);
	cover property (req.write && req.addr == IDENT_OFFSET);
endmodule // charge_current_assertions
bind charge_current_setting_regs charge_current_assertions u_chk (.clk, .rst_n, .req,
	.readData, .readValid, .chargerResetPulse, .setting);
`default_nettype wire

// [host_model.sv]
// Purpose: Host side model that issues register requests.
// Assumes: Requests change at rising clk by non-blocking assignment.
// Notes:   Released address and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input  wire logic                         clk,
	input  wire logic [7:0]                   readData,
	input  wire logic                         readValid,
	output var  charge_current_pkg::reg_req_t req
);
	import charge_current_pkg::*;
	initial req = '0;
	task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		req <= '{w, r, a, d};
		@(posedge clk);
	endtask
	// Releases the request at the edge that took the last one, so that nothing is taken twice.
	task automatic idle();
		req <= '{1'b0, 1'b0, ~req.addr, ~req.data};
	endtask
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		put(1'b0, 1'b1, a, 8'h00);
		idle();
		@(negedge clk);
		d = (readValid === 1'b1) ? readData : 8'hxx;
		@(posedge clk);
	endtask
endmodule // host_model
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the charge current register block.
// Assumes: Host model drives every request.
// Notes:   Reset pulses are counted at each rising edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import charge_current_pkg::*;
	logic            clk = 1'b0;
	logic            rst_n = 1'b0;
	logic [7:0]      readData, got;
	logic            readValid, chargerResetPulse;
	reg_req_t        req;
	charge_setting_t setting;
	int              mismatches = 0, testsRun = 0, pulses = 0, cycles = 0;
	charge_current_setting_regs u_charge_current_setting_regs (.clk, .rst_n, .req,
		.readData, .readValid, .chargerResetPulse, .setting);
	host_model host (.clk, .readData, .readValid, .req);
	initial forever #10 clk = ~clk;
	function automatic charge_setting_t expSet(input logic [2:0] f, input logic [2:0] t);
		return '{f, t, FAST_OFFSET + f * FAST_STEP, TERM_OFFSET + t * TERM_STEP};
	endfunction
	task automatic check(input string what, input logic [25:0] seen, input logic [25:0] exp);
		testsRun++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (chargerResetPulse === 1'b1) pulses++;
		if (cycles == 1000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		host.get(CURRENT_OFFSET, got);
		check("current reg", got, 8'h89);
		host.get(IDENT_OFFSET, got);
		check("ident reg", got, {5'h00, REVISION_CODE});
		check("setting", setting, expSet(3'h0, 3'h1));
		$display("reset test done");
		for (int c = 0; c < 8; c++) begin
			host.put(1'b1, 1'b0, CURRENT_OFFSET, {1'b0, c[2:0], 1'b0, 3'(7 - c)});
			host.get(CURRENT_OFFSET, got);
			check("current reg", got, {1'b1, c[2:0], 1'b0, 3'(7 - c)});
			check("setting", setting, expSet(c[2:0], 3'(7 - c)));
		end
		check("pulse count", 26'(pulses), 26'h000_0000);
		$display("code sweep done");
		host.put(1'b1, 1'b0, CURRENT_OFFSET, 8'hf5);
		host.put(1'b1, 1'b0, IDENT_OFFSET, 8'hff);
		host.get(CURRENT_OFFSET, got);
		check("current reg", got, 8'hf5);
		check("setting", setting, expSet(3'h7, 3'h5));
		host.get(IDENT_OFFSET, got);
		check("ident reg", got, {5'h00, REVISION_CODE});
		check("pulse count", 26'(pulses), 26'h000_0001);
		$display("command test done");
		conclude();
	end
endmodule // tb
`default_nettype wire
